// >>> vt_pkg.sv
/*
  shared constants of the video timing control bank: register offsets,
  field positions, reset values, standards and caption line numbers.
  assumes both ends import it whole.
*/
package vt_pkg;
  // register offsets
  localparam logic [7:0] A_TIO  = 8'h04;
  localparam logic [7:0] A_CLK  = 8'h05;
  localparam logic [7:0] A_AUX  = 8'h06;
  localparam logic [7:0] A_HOST = 8'h0f;
  localparam logic [7:0] A_CO1  = 8'h10;
  localparam logic [7:0] A_CO2  = 8'h11;
  localparam logic [7:0] A_CE1  = 8'h12;
  localparam logic [7:0] A_CE2  = 8'h13;
  // timing_io_control fields
  localparam int B_BTIM = 7;
  localparam int B_BDIR = 5;
  localparam int B_BPOL = 4;
  localparam int B_SDIR = 3;
  localparam int B_HPOL = 2;
  localparam int B_VPOL = 1;
  localparam int B_FPOL = 0;
  // clock_aspect_control and aux_data_enable fields
  localparam int B_CKDIR = 4;
  localparam int B_ASP   = 3;
  localparam int B_CCEV  = 7;
  localparam int B_CCODD = 6;
  // host_control fields
  localparam int B_SRST = 7;
  localparam int B_PD   = 6;
  localparam int B_DIS2 = 5;
  localparam int B_WSO  = 4;
  localparam int B_WSE  = 3;
  localparam int B_DIS1 = 2;
  localparam int B_DISY = 1;
  localparam int B_DISC = 0;
  // writable masks, reserved bits read zero
  localparam logic [7:0] M_TIO  = 8'hbf;
  localparam logic [7:0] M_CLK  = 8'h18;
  localparam logic [7:0] M_AUX  = 8'hc0;
  localparam logic [7:0] M_HOST = 8'h67;
  // reset values
  localparam logic [7:0] R_CFG = 8'h00;
  localparam logic [7:0] R_CAP = 8'h80;
  // video standards
  localparam logic [2:0] STD_NTSC = 3'h0;
  localparam logic [2:0] STD_NSM  = 3'h1;
  localparam logic [2:0] STD_MPAL = 3'h3;
  // caption lines
  localparam logic [9:0] L_OD_NTSC = 10'd21;
  localparam logic [9:0] L_OD_MPAL = 10'd18;
  localparam logic [9:0] L_OD_PAL  = 10'd22;
  localparam logic [9:0] L_EV_NTSC = 10'd284;
  localparam logic [9:0] L_EV_MPAL = 10'd281;
  localparam logic [9:0] L_EV_PAL  = 10'd335;
  // frame geometry
  localparam logic [9:0] N_525   = 10'd525;
  localparam logic [9:0] N_625   = 10'd625;
  localparam logic [9:0] ODD_525 = 10'd263;
  localparam logic [9:0] ODD_625 = 10'd313;
  localparam logic [9:0] VS_LN   = 10'd3;
  localparam logic [4:0] CAP_BITS = 5'd16;
  localparam logic [4:0] SRST_CYC = 5'd16;
endpackage

// >>> vt_if.sv
/*
  wires between the encoder end and the host/source end.
  assumes a testbench resolves two-way pins from the enables.
*/
`timescale 1ns/1ps
`default_nettype none
interface vt_if;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       hs_d, hs_d_oe, vs_d, vs_d_oe, bl_d, bl_d_oe;
  logic       fld_d, pclk_d, pclk_d_oe;
  logic       hs_h, hs_h_oe, vs_h, vs_h_oe, bl_h, bl_h_oe;
  logic       pclk_h, pclk_h_oe;
  logic [7:0] pix;
  modport dev (
    input  wr, rd, addr, wdata, hs_h, vs_h, bl_h, pix,
    output rdata, rvalid, hs_d, hs_d_oe, vs_d, vs_d_oe, bl_d, bl_d_oe,
    output fld_d, pclk_d, pclk_d_oe
  );
  modport hst (
    input  rdata, rvalid, hs_d, bl_d,
    output wr, rd, addr, wdata, hs_h, hs_h_oe, vs_h, vs_h_oe,
    output bl_h, bl_h_oe, pclk_h, pclk_h_oe, pix
  );
endinterface
`default_nettype wire

// >>> vt_dev.sv
/*
  encoder end: control registers, timing master/slave, pixel capture,
  caption serialiser and host control functions.
  assumes the other end runs on the same pixel clock, so its pins are
  read without synchronisers.
*/
`timescale 1ns/1ps
`default_nettype none
module vt_dev
  import vt_pkg::*;
#(
  parameter int H_TOTAL   = 64,
  parameter int H_TOT_SQ  = 72,
  parameter int H_SYNC    = 4,
  parameter int H_BLANK   = 12,
  parameter int CAP_START = 20
) (
  input  wire logic       clk_i,        // pixel clock
  input  wire logic       rst_i,        // sync reset, high
  vt_if.dev               bus,          // register port and pins
  input  wire logic [2:0] video_std_i,  // standard code
  output logic      [7:0] pix_o,        // captured pixel
  output logic            pix_valid_o,  // pixel taken this cycle
  output logic            first_pix_o,  // first pixel of line
  output logic            cap_bit_o,    // caption serial bit
  output logic            cap_valid_o,  // caption bit valid
  output logic            pwr_down_o,   // power-down mode
  output logic      [3:0] dac_dis_o,    // channel disables
  output logic            square_o      // square pixel mode
);
  generate
    if (H_BLANK < 2 || H_SYNC < 1 || CAP_START + 16 >= H_TOTAL ||
        H_TOT_SQ < H_TOTAL || H_TOT_SQ > 1023)
    begin : g_chk
      $error("vt_dev: bad timing parameters");
    end
  endgenerate

  logic [7:0] tio, ckc, aux, hst;
  logic [7:0] co1, co2, ce1, ce2;
  logic       ws_odd, ws_even;
  logic [4:0] srst_cnt;
  logic       srst;
  logic [9:0] hcnt, line, h_tot, n_lines, odd_last, l_od, l_ev;
  logic       hs_in, vs_in, bl_in, hs_p, vs_p, bl_q, bl_now, bl_prev;
  logic       line_st, frame_st, active, act_p;
  logic [15:0] cap_sr;
  logic [4:0] cap_cnt;
  logic       cap_ev, cap_trig, cap_done;

  assign srst = (srst_cnt != 5'd0);

  // configuration writes; reserved bits are masked off at write time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tio <= R_CFG;
      ckc <= R_CFG;
      aux <= R_CFG;
      hst <= R_CFG;
      co1 <= R_CAP;
      co2 <= R_CAP;
      ce1 <= R_CAP;
      ce2 <= R_CAP;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        A_TIO:   tio <= bus.wdata & M_TIO;
        A_CLK:   ckc <= bus.wdata & M_CLK;
        A_AUX:   aux <= bus.wdata & M_AUX;
        A_HOST:  hst <= bus.wdata & M_HOST;
        A_CO1:   co1 <= bus.wdata;
        A_CO2:   co2 <= bus.wdata;
        A_CE1:   ce1 <= bus.wdata;
        A_CE2:   ce2 <= bus.wdata;
        default: ;
      endcase
    end
  end

  // reset sequence; the bit reads back as the running sequence itself
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      srst_cnt <= 5'd0;
    else if (bus.wr && bus.addr == A_HOST && bus.wdata[B_SRST])
      srst_cnt <= SRST_CYC;
    else if (srst)
      srst_cnt <= srst_cnt - 5'd1;
  end

  // write status: a finished send wins over a same-cycle data write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ws_odd  <= 1'b1;
      ws_even <= 1'b1;
    end
    else
    begin
      if (cap_done && !cap_ev)
        ws_odd <= 1'b1;
      else if (bus.wr && (bus.addr == A_CO1 || bus.addr == A_CO2))
        ws_odd <= 1'b0;
      if (cap_done && cap_ev)
        ws_even <= 1'b1;
      else if (bus.wr && (bus.addr == A_CE1 || bus.addr == A_CE2))
        ws_even <= 1'b0;
    end
  end

  // read port: answer one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus.rdata  <= 8'h00;
      bus.rvalid <= 1'b0;
    end
    else
    begin
      bus.rvalid <= bus.rd;
      case (bus.addr)
        A_TIO:   bus.rdata <= tio;
        A_CLK:   bus.rdata <= ckc;
        A_AUX:   bus.rdata <= aux;
        A_HOST:  bus.rdata <= hst | {srst, 2'b00, ws_odd, ws_even, 3'b000};
        A_CO1:   bus.rdata <= co1;
        A_CO2:   bus.rdata <= co2;
        A_CE1:   bus.rdata <= ce1;
        A_CE2:   bus.rdata <= ce2;
        default: bus.rdata <= 8'h00;
      endcase
    end
  end

  // geometry follows the standard and aspect mode
  always_comb
  begin
    h_tot = ckc[B_ASP] ? 10'(H_TOT_SQ - 1) : 10'(H_TOTAL - 1);
    if (video_std_i == STD_NTSC || video_std_i == STD_NSM)
    begin
      n_lines = N_525;
      odd_last = ODD_525;
      l_od = L_OD_NTSC;
      l_ev = L_EV_NTSC;
    end
    else if (video_std_i == STD_MPAL)
    begin
      n_lines = N_525;
      odd_last = ODD_525;
      l_od = L_OD_MPAL;
      l_ev = L_EV_MPAL;
    end
    else
    begin
      n_lines = N_625;
      odd_last = ODD_625;
      l_od = L_OD_PAL;
      l_ev = L_EV_PAL;
    end
  end

  // incoming pins brought to active-high
  assign hs_in = bus.hs_h ^ ~tio[B_HPOL];
  assign vs_in = bus.vs_h ^ ~tio[B_VPOL];
  assign bl_in = bus.bl_h ^ ~tio[B_BPOL];
  assign line_st = tio[B_SDIR] ? (hcnt == h_tot) : (hs_in && !hs_p);
  assign frame_st = tio[B_SDIR] ? (line_st && line == n_lines)
                                : (vs_in && !vs_p);

  // line and pixel counters, free-running or locked to incoming syncs
  always_ff @(posedge clk_i)
  begin
    if (rst_i || srst)
    begin
      hcnt <= 10'd0;
      line <= 10'd1;
      hs_p <= 1'b0;
      vs_p <= 1'b0;
    end
    else
    begin
      hs_p <= hs_in;
      vs_p <= vs_in;
      hcnt <= line_st ? 10'd0 : hcnt + 10'd1;
      if (frame_st)
        line <= 10'd1;
      else if (line_st)
        line <= line + 10'd1;
    end
  end

  // output pins; enables follow the direction bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bl_q <= 1'b1;
      bus.hs_d <= 1'b0;
      bus.vs_d <= 1'b0;
      bus.bl_d <= 1'b0;
      bus.fld_d <= 1'b0;
      bus.hs_d_oe <= 1'b0;
      bus.vs_d_oe <= 1'b0;
      bus.bl_d_oe <= 1'b0;
      bus.pclk_d <= 1'b0;
      bus.pclk_d_oe <= 1'b0;
    end
    else
    begin
      bl_q <= hcnt < 10'(H_BLANK);
      bus.hs_d <= (hcnt < 10'(H_SYNC)) ^ ~tio[B_HPOL];
      bus.vs_d <= (line <= VS_LN) ^ ~tio[B_VPOL];
      bus.bl_d <= (hcnt < 10'(H_BLANK)) ^ ~tio[B_BPOL];
      bus.fld_d <= (line <= odd_last) ^ ~tio[B_FPOL];
      bus.hs_d_oe <= tio[B_SDIR];
      bus.vs_d_oe <= tio[B_SDIR];
      bus.bl_d_oe <= tio[B_BDIR];
      // pixel clock out is half rate, enough to mark direction
      bus.pclk_d <= ckc[B_CKDIR] ? ~bus.pclk_d : 1'b0;
      bus.pclk_d_oe <= ckc[B_CKDIR];
    end
  end

  // pixel capture relative to the blank seen on the pin
  assign bl_now = tio[B_BDIR] ? bl_q : bl_in;
  assign active = !bl_now &&
    ((tio[B_BDIR] && tio[B_BTIM]) || !bl_prev);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bl_prev <= 1'b1;
      act_p <= 1'b0;
      pix_o <= 8'h00;
      pix_valid_o <= 1'b0;
      first_pix_o <= 1'b0;
    end
    else
    begin
      bl_prev <= bl_now;
      act_p <= active;
      pix_o <= bus.pix;
      pix_valid_o <= active;
      first_pix_o <= active && !act_p;
    end
  end

  // caption serialiser, one bit per clock; real rates need a divider
  assign cap_trig = (cap_cnt == 5'd0) && hcnt == 10'(CAP_START) &&
    ((aux[B_CCODD] && line == l_od) || (aux[B_CCEV] && line == l_ev));
  assign cap_done = (cap_cnt == 5'd1);
  always_ff @(posedge clk_i)
  begin
    if (rst_i || srst)
    begin
      cap_sr <= 16'h0000;
      cap_cnt <= 5'd0;
      cap_ev <= 1'b0;
      cap_bit_o <= 1'b0;
      cap_valid_o <= 1'b0;
    end
    else
    begin
      cap_valid_o <= (cap_cnt != 5'd0);
      cap_bit_o <= cap_sr[0];
      if (cap_trig)
      begin
        cap_ev <= (line == l_ev);
        cap_sr <= (line == l_ev) ? {ce2, ce1} : {co2, co1};
        cap_cnt <= CAP_BITS;
      end
      else if (cap_cnt != 5'd0)
      begin
        cap_sr <= {1'b0, cap_sr[15:1]};
        cap_cnt <= cap_cnt - 5'd1;
      end
    end
  end

  // host control outputs; power-down also silences every channel
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwr_down_o <= 1'b0;
      dac_dis_o <= 4'h0;
      square_o <= 1'b0;
    end
    else
    begin
      pwr_down_o <= hst[B_PD];
      dac_dis_o <= {hst[B_DIS2], hst[B_DIS1], hst[B_DISY], hst[B_DISC]}
                   | {4{hst[B_PD]}};
      square_o <= ckc[B_ASP];
    end
  end
endmodule
`default_nettype wire

// >>> vt_host.sv
/*
  host processor and pixel source end: register commands with caption
  handshake, line sync and blank generation when the encoder is slaved (vertical sync held inactive), pixel stream.
  assumes the encoder end shares the pixel clock.
*/
`timescale 1ns/1ps
`default_nettype none
module vt_host
  import vt_pkg::*;
#(
  parameter int H_TOTAL = 64,
  parameter int H_SYNC  = 4,
  parameter int H_BLANK = 12
) (
  input  wire logic       clk_i,       // pixel clock
  input  wire logic       rst_i,       // sync reset, high
  vt_if.hst               bus,         // register port and pins
  input  wire logic       cmd_valid_i, // command offered
  input  wire logic       cmd_write_i, // 1 write, 0 read
  input  wire logic [7:0] cmd_addr_i,  // register offset
  input  wire logic [7:0] cmd_wdata_i, // write data
  input  wire logic       fmt_656_i,   // input format is 656
  output logic            cmd_ready_o, // command taken when high
  output logic            rsp_valid_o, // read data pulse
  output logic      [7:0] rsp_data_o   // read data
);
  generate
    if (H_BLANK < 2 || H_SYNC < 1 || H_TOTAL <= H_BLANK || H_TOTAL > 1023)
    begin : g_chk
      $error("vt_host: bad timing parameters");
    end
  endgenerate

  typedef enum logic [1:0] {ST_IDLE, ST_RDW, ST_POLL} vt_hst_st_t;
  vt_hst_st_t st;
  logic [7:0] tio, ckc, sv_addr, sv_data, wd;
  logic       is_cap, ws_bit, bl_int, bo, bo_p, adv, hs_dp, lst;
  logic [9:0] hcnt;

  assign is_cap = cmd_write_i && (cmd_addr_i == A_CO1 ||
    cmd_addr_i == A_CO2 || cmd_addr_i == A_CE1 || cmd_addr_i == A_CE2);
  assign ws_bit = (sv_addr == A_CO1 || sv_addr == A_CO2) ?
    bus.rdata[B_WSO] : bus.rdata[B_WSE];
  // aspect bit cleared to rectangular in clock writes made while the stream is 656
  assign wd = (cmd_addr_i == A_CLK && fmt_656_i) ?
    (cmd_wdata_i & ~(8'h01 << B_ASP)) : cmd_wdata_i;

  // command engine; caption data waits until its status shows sent
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= ST_IDLE;
      cmd_ready_o <= 1'b1;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 8'h00;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      bus.addr <= 8'h00;
      bus.wdata <= 8'h00;
      sv_addr <= 8'h00;
      sv_data <= 8'h00;
      tio <= R_CFG;
      ckc <= R_CFG;
    end
    else
    begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      rsp_valid_o <= 1'b0;
      case (st)
        ST_IDLE:
          if (cmd_valid_i && cmd_ready_o)
          begin
            sv_addr <= cmd_addr_i;
            sv_data <= wd;
            if (is_cap)
            begin
              bus.rd <= 1'b1;
              bus.addr <= A_HOST;
              cmd_ready_o <= 1'b0;
              st <= ST_POLL;
            end
            else
            begin
              bus.wr <= cmd_write_i;
              bus.rd <= !cmd_write_i;
              bus.addr <= cmd_addr_i;
              bus.wdata <= wd;
              if (cmd_write_i && cmd_addr_i == A_TIO)
                tio <= wd & M_TIO;
              if (cmd_write_i && cmd_addr_i == A_CLK)
                ckc <= wd & M_CLK;
              cmd_ready_o <= cmd_write_i;
              st <= cmd_write_i ? ST_IDLE : ST_RDW;
            end
          end
        ST_RDW:
          if (bus.rvalid)
          begin
            rsp_valid_o <= 1'b1;
            rsp_data_o <= bus.rdata;
            cmd_ready_o <= 1'b1;
            st <= ST_IDLE;
          end
        ST_POLL:
          if (bus.rvalid)
          begin
            if (ws_bit)
            begin
              bus.wr <= 1'b1;
              bus.addr <= sv_addr;
              bus.wdata <= sv_data;
              cmd_ready_o <= 1'b1;
              st <= ST_IDLE;
            end
            else
              bus.rd <= 1'b1;
          end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // own line timing, relocked to the encoder's line sync when it leads
  assign lst = tio[B_SDIR] ? (hs_dp && !(bus.hs_d ^ ~tio[B_HPOL]))
                           : (hcnt == 10'(H_TOTAL - 1));
  assign bl_int = hcnt < 10'(H_BLANK);
  // blank is read back at whichever pin carries it, so pixels line up with what the
  // encoder sees in either direction
  assign bo = (tio[B_BDIR] ? bus.bl_d : bus.bl_h) ^ ~tio[B_BPOL];
  assign adv = !bo && ((tio[B_BDIR] && tio[B_BTIM]) || !bo_p);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hcnt <= 10'd0;
      hs_dp <= 1'b0;
      bo_p <= 1'b1;
      bus.pix <= 8'h00;
      bus.hs_h <= 1'b0;
      bus.vs_h <= 1'b0;
      bus.bl_h <= 1'b0;
      bus.hs_h_oe <= 1'b0;
      bus.vs_h_oe <= 1'b0;
      bus.bl_h_oe <= 1'b0;
      bus.pclk_h <= 1'b0;
      bus.pclk_h_oe <= 1'b0;
    end
    else
    begin
      hs_dp <= bus.hs_d ^ ~tio[B_HPOL];
      hcnt <= lst ? 10'd0 : hcnt + 10'd1;
      bo_p <= bo;
      // first pixel waits on the bus through blanking
      bus.pix <= bo ? 8'h00 : (adv ? bus.pix + 8'h01 : bus.pix);
      bus.hs_h <= (hcnt < 10'(H_SYNC)) ^ ~tio[B_HPOL];
      bus.vs_h <= 1'b0 ^ ~tio[B_VPOL];
      bus.bl_h <= bl_int ^ ~tio[B_BPOL];
      bus.hs_h_oe <= !tio[B_SDIR];
      bus.vs_h_oe <= !tio[B_SDIR];
      bus.bl_h_oe <= !tio[B_BDIR];
      bus.pclk_h <= ckc[B_CKDIR] ? 1'b0 : ~bus.pclk_h;
      bus.pclk_h_oe <= !ckc[B_CKDIR];
    end
  end
endmodule
`default_nettype wire

// >>> vt_sva.sv
/*
  assertions on the register port and pin directions between both ends.
  assumes the testbench wires the interface signals in beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module vt_sva
  import vt_pkg::*;
(
  input wire logic       clk_i,     // pixel clock
  input wire logic       rst_i,     // sync reset, high
  input wire logic       wr,        // write strobe
  input wire logic       rd,        // read strobe
  input wire logic [7:0] addr,      // register offset
  input wire logic [7:0] wdata,     // write data
  input wire logic [7:0] rdata,     // read data
  input wire logic       rvalid,    // read answer
  input wire logic       bl_d_oe,   // blank driven by encoder
  input wire logic       hs_d_oe,   // line sync driven
  input wire logic       vs_d_oe,   // vertical sync driven
  input wire logic       pclk_d_oe  // pixel clock driven
);
  logic [7:0] tio;
  logic [7:0] ckr;
  logic [7:0] aux;
  logic [7:0] host;
  logic [4:0] scnt;
  logic       cap_wr;
  logic       mapped;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // shadow of each configuration register (not the caption data) as the bank should store it
  always_ff @(posedge clk_i)
    if (rst_i)
      {tio, ckr, aux, host} <= '0;
    else if (wr)
    begin
      if (addr == A_TIO) tio <= wdata & M_TIO;
      if (addr == A_CLK) ckr <= wdata & M_CLK;
      if (addr == A_AUX) aux <= wdata & M_AUX;
      if (addr == A_HOST) host <= wdata & M_HOST;
    end

  // cycles since the last soft reset request, saturating so it never wraps
  always_ff @(posedge clk_i)
    if (rst_i)
      scnt <= 5'h1f;
    else if (wr && addr == A_HOST && wdata[B_SRST])
      scnt <= 5'h00;
    else if (scnt != 5'h1f)
      scnt <= scnt + 5'h01;

  // any caption data write since reset may clear a status bit
  always_ff @(posedge clk_i)
    if (rst_i)
      cap_wr <= 1'b0;
    else if (wr && addr >= A_CO1 && addr <= A_CE2)
      cap_wr <= 1'b1;

  assign mapped = addr inside {A_TIO, A_CLK, A_AUX, A_HOST, A_CO1, A_CO2,
                               A_CE1, A_CE2};

  chk_read_answer: assert property (rd |=> rvalid)
    else $error("read strobe got no answer");
  chk_answer_cause: assert property (rvalid |-> $past(rd))
    else $error("answer without a read");
  chk_unmapped_zero: assert property (rd && !mapped |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_blank_dir: assert property
    (!$past(wr) && !$past(wr, 2) |-> bl_d_oe == tio[B_BDIR])
    else $error("blank direction wrong");
  chk_sync_dir: assert property
    (!$past(wr) && !$past(wr, 2) |-> {hs_d_oe, vs_d_oe} == {2{tio[B_SDIR]}})
    else $error("sync direction wrong");
  chk_clock_dir: assert property
    (!$past(wr) && !$past(wr, 2) |-> pclk_d_oe == ckr[B_CKDIR])
    else $error("clock direction wrong");
  chk_timing_readback: assert property
    (rd && addr == A_TIO |=> rdata == $past(tio))
    else $error("timing register readback wrong");
  chk_caption_enable: assert property
    (rd && addr == A_AUX ##1 rvalid |-> rdata == $past(aux))
    else $error("caption enable readback wrong");
  chk_host_bits: assert property
    (rd && addr == A_HOST |=> (rdata & M_HOST) == $past(host))
    else $error("host control readback wrong");
  chk_status_reset: assert property
    (rd && addr == A_HOST && !cap_wr |=> rdata[4:3] == 2'b11)
    else $error("caption status not set after reset");
  chk_srst_hold: assert property
    (rd && addr == A_HOST && scnt <= 5'd12 |=> rdata[B_SRST])
    else $error("soft reset bit dropped early");
  chk_srst_clear: assert property
    (rd && addr == A_HOST && scnt >= 5'd20 |=> !rdata[B_SRST])
    else $error("soft reset bit not cleared");

  cover property (wr && addr == A_HOST && wdata[B_SRST]);
  cover property (bl_d_oe && hs_d_oe);
  cover property (wr && addr == A_CO2 ##[1:4] rd && addr == A_HOST);
endmodule
`default_nettype wire

// >>> tb.sv
/*
  testbench joining the encoder end and the host end through the interface.
  assumes both ends share the pixel clock and the package constants.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vt_pkg::*;
  localparam int HT = 48;
  localparam int HS = 4;
  localparam logic [7:0] RA [7] = '{A_TIO, A_CLK, A_AUX, A_HOST, A_CO1,
                                    A_CE2, 8'h30};
  localparam logic [7:0] RE [7] = '{8'h00, 8'h00, 8'h00, 8'h18, R_CAP,
                                    R_CAP, 8'h00};
  localparam logic [7:0] PT [5] = '{8'hbc, 8'h38, 8'h9c, 8'ha8, 8'h14};
  localparam int         PD [5] = '{1, 2, 2, 1, 2};
  logic       clk, rst, cv, cw, f656, rdy, rv, pv, fp, cb, cvld, pd, sq;
  logic [7:0] ca, cd, rdat, px, a, d;
  logic [3:0] dis;
  logic [2:0] vstd;
  int         n_fail, samples_checked;

  vt_if i_vt_if ();
  vt_dev #(.H_TOTAL(HT), .H_TOT_SQ(HT + 8), .H_SYNC(HS), .H_BLANK(12),
    .CAP_START(20)) i_vt_dev (.clk_i(clk), .rst_i(rst), .bus(i_vt_if.dev),
    .video_std_i(vstd), .pix_o(px), .pix_valid_o(pv), .first_pix_o(fp),
    .cap_bit_o(cb), .cap_valid_o(cvld), .pwr_down_o(pd), .dac_dis_o(dis),
    .square_o(sq));
  vt_host #(.H_TOTAL(HT), .H_SYNC(HS), .H_BLANK(12)) i_vt_host (.clk_i(clk),
    .rst_i(rst), .bus(i_vt_if.hst), .cmd_valid_i(cv), .cmd_write_i(cw),
    .cmd_addr_i(ca), .cmd_wdata_i(cd), .fmt_656_i(f656), .cmd_ready_o(rdy),
    .rsp_valid_o(rv), .rsp_data_o(rdat));
  vt_sva i_vt_sva (.clk_i(clk), .rst_i(rst), .wr(i_vt_if.wr),
    .rd(i_vt_if.rd), .addr(i_vt_if.addr), .wdata(i_vt_if.wdata),
    .rdata(i_vt_if.rdata), .rvalid(i_vt_if.rvalid),
    .bl_d_oe(i_vt_if.bl_d_oe), .hs_d_oe(i_vt_if.hs_d_oe),
    .vs_d_oe(i_vt_if.vs_d_oe), .pclk_d_oe(i_vt_if.pclk_d_oe));

  // expected readback: reserved bits zero, status bits idle at one
  function automatic logic [7:0] exp_rd(input logic [7:0] ad, dd,
                                        input logic f);
    case (ad)
      A_TIO: return dd & M_TIO;
      A_CLK: return dd & M_CLK & (f ? 8'hf7 : 8'hff);
      A_AUX: return dd & M_AUX;
      default: return (dd & M_HOST) | 8'h18;
    endcase
  endfunction

  // pins watched by the timing scenarios
  function automatic logic pin(input int sel);
    case (sel)
      0: return i_vt_if.hs_d;
      1: return i_vt_if.bl_d;
      2: return i_vt_if.bl_h;
      default: return fp;
    endcase
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // count falling edges while a pin stays at a level, bounded
  task automatic hold(input int sel, input logic lvl, output int k);
    k = 0;
    while (pin(sel) === lvl && k < 400)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 400)
      n_fail++;
  endtask

  // command stays offered until an edge sees ready high
  task automatic cmd(input logic w, input logic [7:0] ad, dd);
    int k;
    @(negedge clk);
    {cv, cw, ca, cd} = {1'b1, w, ad, dd};
    k = 0;
    // ready is settled at a falling edge; the next rising edge takes it
    while (rdy !== 1'b1 && k < 60000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 60000)
      n_fail++;
    @(negedge clk);
    cv = 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, exp, m);
    int k;
    cmd(1'b0, ad, 8'h00);
    k = 0;
    while (rv !== 1'b1 && k < 8)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 8)
      n_fail++;
    chk8(rdat & m, exp);
  endtask

  // second byte only, so one frame suffices; first byte keeps its reset
  task automatic cap_case(input logic [7:0] en, ad, input int sb,
                          input logic [9:0] ln);
    logic [15:0] got;
    logic [7:0]  y;
    int          k;
    y = 8'($urandom);
    cmd(1'b1, A_AUX, en);
    cmd(1'b1, ad, y);
    rd(A_HOST, 8'h00, 8'(1 << sb));
    k = 0;
    while (cvld !== 1'b1 && k < 40000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 40000)
      n_fail++;
    // the line counter still shows the line that started the send
    chk8(i_vt_dev.line[7:0], ln[7:0]);
    for (int i = 0; i < 16; i++)
    begin
      got[i] = cb;
      @(negedge clk);
    end
    chk8(got[7:0], R_CAP);
    chk8(got[15:8], y);
    rd(A_HOST, 8'(1 << sb), 8'(1 << sb));
  endtask

  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // watchdog: two caption frames plus the rest fit well inside this
  initial
  begin
    repeat (90000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial
  begin
    int k;
    {cv, cw, f656, ca, cd, a, d, n_fail, samples_checked} = '0;
    vstd = STD_NTSC;
    rst = 1'b1;
    void'($urandom(32'h316c3bd2));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 7; i++)
      rd(RA[i], RE[i], 8'hff);
    $display("test reset values done");
    // all-ones corners first (host soft reset bit kept clear), then random data
    for (int i = 0; i < 16; i++)
    begin
      a = RA[i % 4];
      d = (i < 4) ? 8'hff : 8'($urandom);
      d[B_SRST] = (a == A_HOST) ? 1'b0 : d[B_SRST];
      f656 = 1'($urandom);
      cmd(1'b1, a, d);
      rd(a, exp_rd(a, d, f656), 8'hff);
      if (a == A_HOST)
        chk8({3'h0, pd, dis}, {3'h0, d[6], {d[5], d[2:0]} | {4{d[6]}}});
      if (a == A_CLK)
        chk8({7'h0, sq}, {7'h0, d[B_ASP] & ~f656});
    end
    $display("test register access done");
    cmd(1'b1, A_HOST, 8'h80);
    rd(A_HOST, 8'h80, 8'h80);
    repeat (30) @(negedge clk);
    rd(A_HOST, 8'h00, 8'h80);
    $display("test soft reset done");
    cmd(1'b1, A_CLK, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      cmd(1'b1, A_TIO, PT[i]);
      repeat (2 * HT) @(negedge clk);
      hold(PT[i][5] ? 1 : 2, ~PT[i][4], k);
      hold(PT[i][5] ? 1 : 2, PT[i][4], k);
      hold(3, 1'b0, k);
      chk8(8'(k), 8'(PD[i]));
      // first captured pixel is the one held through blanking
      chk8({pv, px[6:0]}, 8'h80);
      @(negedge clk);
      chk8(px, 8'h01);
      hold(0, PT[i][2], k);
      hold(0, ~PT[i][2], k);
      hold(0, PT[i][2], k);
      chk8(8'(k), 8'(HS));
    end
    $display("test pixel timing done");
    cmd(1'b1, A_TIO, 8'h08);
    cap_case(8'h40, A_CO2, B_WSO, L_OD_NTSC);
    vstd = STD_MPAL;
    cap_case(8'h80, A_CE2, B_WSE, L_EV_MPAL);
    $display("test captions done");
    test_done();
  end
endmodule
`default_nettype wire
